// ---- rtl/fpls_pkg.sv ----
package fpls_pkg;
    // instruction word fields
    localparam int COND_HI = 31;
    localparam int COND_LO = 28;
    localparam int P_BIT = 24;
    localparam int U_BIT = 23;
    localparam int D_BIT = 22;
    localparam int W_BIT = 21;
    localparam int L_BIT = 20;
    localparam int RN_HI = 19;
    localparam int RN_LO = 16;
    localparam int FD_HI = 15;
    localparam int FD_LO = 12;
    localparam int CP_HI = 11;
    localparam int CP_LO = 8;
    localparam int OFF_HI = 7;
    localparam int OFF_LO = 0;
    localparam int WORD_SHIFT = 2;
    // coprocessor numbers
    localparam logic [3:0] CP_SINGLE = 4'ha;
    localparam logic [3:0] CP_DOUBLE = 4'hb;
    // index bit patterns p,u,w
    localparam logic [2:0] PUW_TWO = 3'h0;
    localparam logic [2:0] PUW_UND_A = 3'h1;
    localparam logic [2:0] PUW_UNIDX = 3'h2;
    localparam logic [2:0] PUW_INC = 3'h3;
    localparam logic [2:0] PUW_NEG = 3'h4;
    localparam logic [2:0] PUW_DEC = 3'h5;
    localparam logic [2:0] PUW_POS = 3'h6;
    localparam logic [2:0] PUW_UND_B = 3'h7;
    // register map, byte addresses
    localparam logic [4:0] ADR_CTRL = 5'h00;
    localparam logic [4:0] ADR_INSTR = 5'h04;
    localparam logic [4:0] ADR_BASE = 5'h08;
    localparam logic [4:0] ADR_STAT = 5'h0c;
    localparam logic [4:0] ADR_START = 5'h10;
    localparam logic [4:0] ADR_WBACK = 5'h14;
    localparam logic [4:0] ADR_DATA = 5'h18;
    localparam int CTRL_GO_BIT = 0;
    localparam logic [31:0] INSTR_RST = 32'h0;
    localparam logic [31:0] BASE_RST = 32'h0;
    localparam logic [31:0] WORD_BYTES = 32'h4;

    typedef enum logic [2:0] {CLS_TWO_REG, CLS_UNDEF, CLS_NOT_FP, CLS_MULTI, CLS_SINGLE}
        fpls_cls_type;
    typedef enum logic [2:0] {MODE_NONE, MODE_UNIDX, MODE_INC, MODE_DEC, MODE_NEG, MODE_POS}
        fpls_mode_type;
    typedef enum logic {ST_IDLE, ST_XFER} fpls_state_type;

    typedef struct packed {
        fpls_cls_type cls;
        fpls_mode_type mode;
        logic load;
        logic dbl;
        logic unknown;
        logic wb_en;
        logic wb_early;
        logic [3:0] base_idx;
        logic [4:0] first_word;
        logic [7:0] count;
        logic [7:0] words;
        logic [31:0] start_addr;
        logic [31:0] wb_addr;
    } fpls_dec_type;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] left;
        logic [4:0] rsvd;
        logic refused;
        logic busy;
        logic unknown;
        logic dbl;
        logic load;
        fpls_mode_type mode;
        fpls_cls_type cls;
    } fpls_stat_type;
endpackage : fpls_pkg

// ---- rtl/fpls_decode.sv ----
`timescale 1ns/1ps
module fpls_decode
    import fpls_pkg::*;
(
    // instruction and base value
    input wire logic [31:0] instr_i,
    input wire logic [31:0] base_i,
    // decoded view
    output fpls_dec_type dec_o
);
    logic [2:0] puw;
    logic [3:0] cp;
    logic [7:0] off;
    logic [31:0] byte_off;
    logic d_bit;

    assign puw = {instr_i[P_BIT], instr_i[U_BIT], instr_i[W_BIT]};
    assign cp = instr_i[CP_HI:CP_LO];
    assign off = instr_i[OFF_HI:OFF_LO];
    assign d_bit = instr_i[D_BIT];
    assign byte_off = 32'(off) << WORD_SHIFT;

    always_comb
    begin
        dec_o = '0;
        dec_o.load = instr_i[L_BIT];
        dec_o.base_idx = instr_i[RN_HI:RN_LO];
        dec_o.dbl = (cp == CP_DOUBLE);
        dec_o.first_word = dec_o.dbl ? {instr_i[FD_HI:FD_LO], 1'b0}
                                     : {instr_i[FD_HI:FD_LO], d_bit};
        dec_o.start_addr = base_i;
        dec_o.wb_addr = base_i;
        unique case (puw)
            PUW_TWO:
                dec_o.cls = CLS_TWO_REG;
            PUW_UND_A, PUW_UND_B:
                dec_o.cls = CLS_UNDEF;
            PUW_UNIDX:
            begin
                dec_o.cls = CLS_MULTI;
                dec_o.mode = MODE_UNIDX;
            end
            PUW_INC:
            begin
                dec_o.cls = CLS_MULTI;
                dec_o.mode = MODE_INC;
                dec_o.wb_en = 1'b1;
                dec_o.wb_addr = base_i + byte_off;
            end
            PUW_DEC:
            begin
                dec_o.cls = CLS_MULTI;
                dec_o.mode = MODE_DEC;
                dec_o.wb_en = 1'b1;
                dec_o.wb_early = 1'b1;
                dec_o.start_addr = base_i - byte_off;
                dec_o.wb_addr = base_i - byte_off;
            end
            PUW_NEG:
            begin
                dec_o.cls = CLS_SINGLE;
                dec_o.mode = MODE_NEG;
                dec_o.start_addr = base_i - byte_off;
            end
            PUW_POS:
            begin
                dec_o.cls = CLS_SINGLE;
                dec_o.mode = MODE_POS;
                dec_o.start_addr = base_i + byte_off;
            end
        endcase
        if (dec_o.cls == CLS_MULTI)
        begin
            dec_o.count = dec_o.dbl ? {1'b0, off[7:1]} : off;
            dec_o.unknown = dec_o.dbl && off[0];
            dec_o.words = dec_o.dbl ? {off[7:1], 1'b0} : off;
        end
        else if (dec_o.cls == CLS_SINGLE)
        begin
            dec_o.count = 8'h01;
            dec_o.words = dec_o.dbl ? 8'h02 : 8'h01;
        end
        if (dec_o.cls == CLS_MULTI || dec_o.cls == CLS_SINGLE)
        begin
            if (cp != CP_SINGLE && cp != CP_DOUBLE)
                dec_o.cls = CLS_NOT_FP;
            else if (dec_o.dbl && d_bit)
                dec_o.cls = CLS_UNDEF;
        end
    end
endmodule : fpls_decode

// ---- rtl/fpls_load_store.sv ----
// Notes on behaviour
// - only coprocessor codes 0xa (single) and 0xb (double/unknown) are accepted.
// - fields: cond 31:28, p24, u23, d22, w21, l20, base 19:16, reg 15:12, cp 11:8, offset 7:0.
// - index bits 000 always mean a two-register transfer.
// - index bits 001 or 111 are undefined.
// - 010/011/101 give multiple transfer, unindexed/increment/decrement; l selects load.
// - count is offset singles, offset/2 doubles, or (offset-1)/2 unknown-precision doubles.
// - 100/110 move one register at base minus/plus offset.
// - transfers copy words unchanged and raise no exception.
// - no nan handling or flush-to-zero is applied to transfers.
// - signaling nans pass unchanged with no invalid-operation flag.
// - denormals pass unchanged even in flush-to-zero mode.
// - increment starts at base, then writes base plus four times offset back.
// - decrement starts at base minus four times offset, written back first.
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module fpls_load_store
    import fpls_pkg::*;
#(
    parameter int REG_WORDS = 32
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    generate
        if (REG_WORDS != 32)
        begin : g_bad_size
            $error("REG_WORDS must be 32");
        end
    endgenerate

    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] instr_reg;
    logic [31:0] base_reg;
    fpls_dec_type dec;
    fpls_dec_type dec_reg;
    fpls_state_type state_reg;
    logic [4:0] word_idx_reg;
    logic [7:0] left_reg;
    logic [31:0] cur_addr_reg;
    logic refused_reg;
    logic [31:0] reg_file [REG_WORDS];
    logic req;
    logic acc;
    logic go;
    logic start_ok;
    logic step;
    logic last_step;
    fpls_stat_type stat;
    logic [31:0] rd_mux;

    fpls_decode u_decode
    (
        .instr_i(instr_reg),
        .base_i(base_reg),
        .dec_o(dec)
    );

    assign req = avs_read_i || avs_write_i;
    assign acc = req && !wait_reg;
    assign go = acc && avs_write_i && (avs_address_i == ADR_CTRL)
                && avs_writedata_i[CTRL_GO_BIT];
    assign start_ok = (state_reg == ST_IDLE)
                      && (dec.cls == CLS_MULTI || dec.cls == CLS_SINGLE);
    assign step = acc && (state_reg == ST_XFER) && (avs_address_i == ADR_DATA)
                  && (dec_reg.load ? avs_write_i : avs_read_i);
    assign last_step = step && (left_reg == 8'h01);
    assign avs_waitrequest_o = wait_reg;
    assign avs_readdata_o = rdata_reg;

    // bus handshake: one wait cycle per access
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            wait_reg <= 1'b1;
        else if (req && wait_reg)
            wait_reg <= 1'b0;
        else
            wait_reg <= 1'b1;
    end

    always_comb
    begin
        stat = '0;
        stat.cls = dec.cls;
        stat.mode = dec.mode;
        stat.load = dec.load;
        stat.dbl = dec.dbl;
        stat.unknown = dec.unknown;
        stat.busy = (state_reg == ST_XFER);
        stat.refused = refused_reg;
        stat.count = dec.count;
        stat.left = left_reg;
        unique case (avs_address_i)
            ADR_CTRL:
                rd_mux = 32'h0;
            ADR_INSTR:
                rd_mux = instr_reg;
            ADR_BASE:
                rd_mux = base_reg;
            ADR_STAT:
                rd_mux = stat;
            ADR_START:
                rd_mux = (state_reg == ST_XFER) ? cur_addr_reg : dec.start_addr;
            ADR_WBACK:
                rd_mux = dec.wb_addr;
            ADR_DATA:
                rd_mux = (state_reg == ST_XFER && !dec_reg.load)
                         ? reg_file[word_idx_reg] : 32'h0;
            default:
                rd_mux = 32'h0;
        endcase
    end

    // read data settles while waitrequest is high
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_reg <= 32'h0;
        else if (avs_read_i && wait_reg)
            rdata_reg <= rd_mux;
    end

    // instruction word, locked while busy
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            instr_reg <= INSTR_RST;
        else if (acc && avs_write_i && avs_address_i == ADR_INSTR && state_reg == ST_IDLE)
            instr_reg <= avs_writedata_i;
    end

    // base value with writeback
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            base_reg <= BASE_RST;
        else if (go && start_ok && dec.wb_en && (dec.wb_early || dec.words == 8'h00))
            base_reg <= dec.wb_addr;
        else if (last_step && dec_reg.wb_en && !dec_reg.wb_early)
            base_reg <= dec_reg.wb_addr;
        else if (acc && avs_write_i && avs_address_i == ADR_BASE && state_reg == ST_IDLE)
            base_reg <= avs_writedata_i;
    end

    // transfer sequencer
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_IDLE;
            dec_reg <= '0;
            word_idx_reg <= 5'h00;
            left_reg <= 8'h00;
            cur_addr_reg <= 32'h0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                    if (go && start_ok)
                    begin
                        dec_reg <= dec;
                        word_idx_reg <= dec.first_word;
                        left_reg <= dec.words;
                        cur_addr_reg <= dec.start_addr;
                        if (dec.words != 8'h00)
                            state_reg <= ST_XFER;
                    end
                ST_XFER:
                    if (step)
                    begin
                        word_idx_reg <= word_idx_reg + 5'h01;
                        cur_addr_reg <= cur_addr_reg + WORD_BYTES;
                        left_reg <= left_reg - 8'h01;
                        if (last_step)
                            state_reg <= ST_IDLE;
                    end
            endcase
        end
    end

    // refused start: go while busy, undefined, two-register or foreign code
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            refused_reg <= 1'b0;
        else if (go)
            refused_reg <= !start_ok;
    end

    // raw word copy, no nan or flush handling
    always_ff @(posedge mclk_i)
    begin
        if (step && dec_reg.load)
            reg_file[word_idx_reg] <= avs_writedata_i;
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    logic [2:0] puw_a;
    assign puw_a = {instr_reg[P_BIT], instr_reg[U_BIT], instr_reg[W_BIT]};

    property p_cp_accept;
        (dec.cls == CLS_MULTI || dec.cls == CLS_SINGLE)
            |-> (instr_reg[CP_HI:CP_LO] == CP_SINGLE || instr_reg[CP_HI:CP_LO] == CP_DOUBLE);
    endproperty
    a_cp_accept: assert property (p_cp_accept) else $error("foreign cp accepted");

    property p_fields;
        dec.base_idx == instr_reg[RN_HI:RN_LO] && dec.load == instr_reg[L_BIT];
    endproperty
    a_fields: assert property (p_fields) else $error("field split wrong");

    property p_two_reg;
        puw_a == PUW_TWO |-> dec.cls == CLS_TWO_REG;
    endproperty
    a_two_reg: assert property (p_two_reg) else $error("000 not two-register");

    property p_undef;
        (puw_a == PUW_UND_A || puw_a == PUW_UND_B) |-> dec.cls == CLS_UNDEF;
    endproperty
    a_undef: assert property (p_undef) else $error("001/111 not undefined");

    property p_inc_single;
        (puw_a == PUW_INC && instr_reg[CP_HI:CP_LO] == CP_SINGLE)
            |-> dec.mode == MODE_INC && dec.count == instr_reg[OFF_HI:OFF_LO];
    endproperty
    a_inc_single: assert property (p_inc_single) else $error("increment count wrong");

    property p_dbl_count;
        (dec.cls == CLS_MULTI && dec.dbl)
            |-> dec.count == {1'b0, instr_reg[OFF_HI:OFF_LO + 1]} && dec.words == {dec.count[6:0], 1'b0};
    endproperty
    a_dbl_count: assert property (p_dbl_count) else $error("double count wrong");

    property p_one_reg;
        (puw_a == PUW_POS && dec.cls == CLS_SINGLE)
            |-> dec.words == (dec.dbl ? 8'h02 : 8'h01)
                && dec.start_addr == base_reg + (32'(instr_reg[OFF_HI:OFF_LO]) << WORD_SHIFT);
    endproperty
    a_one_reg: assert property (p_one_reg) else $error("single transfer wrong");

    property p_neg_one;
        (puw_a == PUW_NEG && dec.cls == CLS_SINGLE)
            |-> dec.start_addr == base_reg - (32'(instr_reg[OFF_HI:OFF_LO]) << WORD_SHIFT);
    endproperty
    a_neg_one: assert property (p_neg_one) else $error("negative offset wrong");

    property p_one_known;
        dec.cls == CLS_SINGLE |-> !dec.unknown;
    endproperty
    a_one_known: assert property (p_one_known) else $error("single marked unknown");

    property p_load_copy;
        (step && dec_reg.load)
            |=> reg_file[$past(word_idx_reg)] == $past(avs_writedata_i);
    endproperty
    a_load_copy: assert property (p_load_copy) else $error("loaded word altered");

    property p_store_copy;
        (avs_read_i && wait_reg && avs_address_i == ADR_DATA && state_reg == ST_XFER
            && !dec_reg.load) |=> avs_readdata_o == reg_file[word_idx_reg];
    endproperty
    a_store_copy: assert property (p_store_copy) else $error("stored word altered");

    property p_inc_wb;
        (last_step && dec_reg.mode == MODE_INC) |=> base_reg == $past(dec_reg.wb_addr);
    endproperty
    a_inc_wb: assert property (p_inc_wb) else $error("increment writeback wrong");

    property p_dec_wb;
        (go && start_ok && dec.mode == MODE_DEC)
            |=> base_reg == $past(dec.wb_addr) && cur_addr_reg == base_reg;
    endproperty
    a_dec_wb: assert property (p_dec_wb) else $error("decrement writeback wrong");

    property p_d_bit;
        (dec.dbl && instr_reg[D_BIT] && puw_a != PUW_TWO) |-> dec.cls == CLS_UNDEF;
    endproperty
    a_d_bit: assert property (p_d_bit) else $error("double with d set accepted");

    property p_ascend;
        (step && !last_step) |=> word_idx_reg == $past(word_idx_reg) + 5'h01
            && cur_addr_reg == $past(cur_addr_reg) + WORD_BYTES;
    endproperty
    a_ascend: assert property (p_ascend) else $error("order not ascending");

    property p_wait;
        (req && wait_reg) |=> !wait_reg ##1 wait_reg;
    endproperty
    a_wait: assert property (p_wait) else $error("waitrequest timing wrong");
endmodule : fpls_load_store

// ---- bench/fpls_core_model.sv ----
`timescale 1ns/1ps
module fpls_core_model
(
    // clock
    input wire logic mclk_i,
    // avalon-mm master side
    output logic [4:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [31:0] avs_writedata_o,
    input wire logic [31:0] avs_readdata_i,
    input wire logic avs_waitrequest_i
);
    initial
    begin
        avs_address_o = 5'h00;
        avs_read_o = 1'b0;
        avs_write_o = 1'b0;
        avs_writedata_o = 32'h0;
    end

    // write, held until waitrequest seen low
    task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
        @(posedge mclk_i);
        avs_address_o <= adr;
        avs_writedata_o <= dat;
        avs_write_o <= 1'b1;
        do
            @(posedge mclk_i);
        while (avs_waitrequest_i !== 1'b0);
        avs_write_o <= 1'b0;
        avs_writedata_o <= ~dat;
    endtask : wr

    // read, data taken at the completing edge
    task automatic rd(input logic [4:0] adr, output logic [31:0] dat);
        @(posedge mclk_i);
        avs_address_o <= adr;
        avs_read_o <= 1'b1;
        do
            @(posedge mclk_i);
        while (avs_waitrequest_i !== 1'b0);
        dat = avs_readdata_i;
        avs_read_o <= 1'b0;
    endtask : rd
endmodule : fpls_core_model

// ---- bench/fp_coproc_load_store_decode_test.sv ----
`timescale 1ns/1ps
module fp_coproc_load_store_decode_test;
    import fpls_pkg::*;
    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] stat;
        logic [31:0] smask;
        logic [31:0] start;
        logic [31:0] wback;
        logic [1:0] chk;
    } fpls_row_type;

    logic mclk_i;
    logic rst_i;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    fpls_row_type rows [10];
    logic [31:0] v;
    logic [31:0] w [3];

    fpls_load_store #(.REG_WORDS(32)) i_fpls_load_store (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .avs_address_i(avs_address),
        .avs_read_i(avs_read),
        .avs_write_i(avs_write),
        .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest)
    );

    fpls_core_model i_fpls_core_model (
        .mclk_i(mclk_i),
        .avs_address_o(avs_address),
        .avs_read_o(avs_read),
        .avs_write_o(avs_write),
        .avs_writedata_o(avs_writedata),
        .avs_readdata_i(avs_readdata),
        .avs_waitrequest_i(avs_waitrequest)
    );

    function automatic logic [31:0] mk(input logic [2:0] puw, input logic d, input logic l,
        input logic [3:0] fd, input logic [3:0] cp, input logic [7:0] off);
        mk = {4'he, 3'h6, puw[2], puw[1], d, puw[0], l, 4'h1, fd, cp, off};
    endfunction : mk

    function automatic logic [31:0] st(input fpls_cls_type c, input fpls_mode_type m,
        input logic l, input logic d, input logic u, input logic [7:0] n);
        st = {n, 8'h00, 7'h00, u, d, l, m, c};
    endfunction : st

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic go(input logic [31:0] ins, input logic [31:0] base);
        i_fpls_core_model.wr(ADR_INSTR, ins);
        i_fpls_core_model.wr(ADR_BASE, base);
        i_fpls_core_model.wr(ADR_CTRL, 32'h1);
    endtask : go

    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            conclude();
        end
    end

    initial
    begin
        rst_i = 1'b1;
        rows[0] = '{mk(3'h0, 1'b0, 1'b0, 4'h2, CP_SINGLE, 8'h04),
            st(CLS_TWO_REG, MODE_NONE, 1'b0, 1'b0, 1'b0, 8'h0), 32'h7, 32'h0, 32'h0, 2'h0};
        rows[1] = '{mk(3'h1, 1'b0, 1'b1, 4'h2, CP_DOUBLE, 8'h04),
            st(CLS_UNDEF, MODE_NONE, 1'b0, 1'b0, 1'b0, 8'h0), 32'h7, 32'h0, 32'h0, 2'h0};
        rows[2] = '{mk(3'h7, 1'b0, 1'b0, 4'h2, CP_SINGLE, 8'h04),
            st(CLS_UNDEF, MODE_NONE, 1'b0, 1'b0, 1'b0, 8'h0), 32'h7, 32'h0, 32'h0, 2'h0};
        rows[3] = '{mk(3'h2, 1'b0, 1'b0, 4'h2, CP_SINGLE, 8'h05),
            st(CLS_MULTI, MODE_UNIDX, 1'b0, 1'b0, 1'b0, 8'h5), 32'hff0001ff, 32'h1000,
            32'h1000, 2'h3};
        rows[4] = '{mk(3'h3, 1'b0, 1'b1, 4'h2, CP_DOUBLE, 8'h06),
            st(CLS_MULTI, MODE_INC, 1'b1, 1'b1, 1'b0, 8'h3), 32'hff0001ff, 32'h1000,
            32'h1018, 2'h3};
        rows[5] = '{mk(3'h5, 1'b0, 1'b0, 4'h2, CP_DOUBLE, 8'h07),
            st(CLS_MULTI, MODE_DEC, 1'b0, 1'b1, 1'b1, 8'h3), 32'hff0001ff, 32'h0fe4,
            32'h0fe4, 2'h3};
        rows[6] = '{mk(3'h4, 1'b1, 1'b1, 4'h2, CP_SINGLE, 8'h03),
            st(CLS_SINGLE, MODE_NEG, 1'b1, 1'b0, 1'b0, 8'h0), 32'h1ff, 32'h0ff4, 32'h0, 2'h2};
        rows[7] = '{mk(3'h6, 1'b0, 1'b0, 4'h2, CP_DOUBLE, 8'h03),
            st(CLS_SINGLE, MODE_POS, 1'b0, 1'b1, 1'b0, 8'h0), 32'h1ff, 32'h100c, 32'h0, 2'h2};
        rows[8] = '{mk(3'h2, 1'b0, 1'b0, 4'h2, 4'h9, 8'h04),
            st(CLS_NOT_FP, MODE_NONE, 1'b0, 1'b0, 1'b0, 8'h0), 32'h7, 32'h0, 32'h0, 2'h0};
        rows[9] = '{mk(3'h3, 1'b1, 1'b1, 4'h2, CP_DOUBLE, 8'h04),
            st(CLS_UNDEF, MODE_NONE, 1'b0, 1'b0, 1'b0, 8'h0), 32'h7, 32'h0, 32'h0, 2'h0};
        w = '{32'h7f800001, 32'h00000001, 32'h80000003};
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        // reset values, idle data port, unmapped place
        i_fpls_core_model.rd(ADR_INSTR, v);
        check(v, INSTR_RST);
        i_fpls_core_model.rd(ADR_BASE, v);
        check(v, BASE_RST);
        i_fpls_core_model.rd(ADR_DATA, v);
        check(v, 32'h0);
        i_fpls_core_model.rd(5'h1c, v);
        check(v, 32'h0);
        // decode table
        i_fpls_core_model.wr(ADR_BASE, 32'h1000);
        foreach (rows[i])
        begin
            i_fpls_core_model.wr(ADR_INSTR, rows[i].instr);
            i_fpls_core_model.rd(ADR_STAT, v);
            check(v & rows[i].smask, rows[i].stat);
            i_fpls_core_model.rd(ADR_START, v);
            if (rows[i].chk[1])
                check(v, rows[i].start);
            i_fpls_core_model.rd(ADR_WBACK, v);
            if (rows[i].chk[0])
                check(v, rows[i].wback);
        end
        // load three singles, increment, nan and denormal words
        go(mk(3'h3, 1'b0, 1'b1, 4'h2, CP_SINGLE, 8'h03), 32'h100);
        i_fpls_core_model.rd(ADR_STAT, v);
        check(v & 32'h00ff0600, 32'h00030200);
        foreach (w[i])
            i_fpls_core_model.wr(ADR_DATA, w[i]);
        i_fpls_core_model.rd(ADR_BASE, v);
        check(v, 32'h10c);
        i_fpls_core_model.rd(ADR_STAT, v);
        check(v & 32'h200, 32'h0);
        // store them back unchanged
        go(mk(3'h2, 1'b0, 1'b0, 4'h2, CP_SINGLE, 8'h03), 32'h100);
        foreach (w[i])
        begin
            i_fpls_core_model.rd(ADR_DATA, v);
            check(v, w[i]);
        end
        // load one double, decrement, then read it as two singles
        go(mk(3'h5, 1'b0, 1'b1, 4'h3, CP_DOUBLE, 8'h02), 32'h200);
        i_fpls_core_model.rd(ADR_BASE, v);
        check(v, 32'h1f8);
        i_fpls_core_model.wr(ADR_DATA, 32'ha5a50001);
        i_fpls_core_model.wr(ADR_DATA, 32'h5a5a0002);
        go(mk(3'h2, 1'b0, 1'b0, 4'h3, CP_SINGLE, 8'h02), 32'h1f8);
        i_fpls_core_model.rd(ADR_DATA, v);
        check(v, 32'ha5a50001);
        i_fpls_core_model.rd(ADR_DATA, v);
        check(v, 32'h5a5a0002);
        i_fpls_core_model.rd(ADR_BASE, v);
        check(v, 32'h1f8);
        // go on an undefined encoding is refused
        go(mk(3'h7, 1'b0, 1'b1, 4'h2, CP_SINGLE, 8'h02), 32'h300);
        i_fpls_core_model.rd(ADR_STAT, v);
        check(v & 32'h607, 32'h401);
        // one double at base plus offset, cut by a reset
        go(mk(3'h6, 1'b0, 1'b1, 4'h4, CP_DOUBLE, 8'h01), 32'h500);
        i_fpls_core_model.rd(ADR_START, v);
        check(v, 32'h504);
        i_fpls_core_model.rd(ADR_STAT, v);
        check(v & 32'h00ff0200, 32'h00020200);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        i_fpls_core_model.rd(ADR_STAT, v);
        check(v, 32'h0);
        i_fpls_core_model.rd(ADR_BASE, v);
        check(v, BASE_RST);
        conclude();
    end
endmodule : fp_coproc_load_store_decode_test
